// >>> design/sfalu_top.sv
// Subtract-from execution unit: decodes one issued instruction a cycle,
// writes the result back one cycle later and keeps the carry, overflow,
// summary-overflow and condition-field-zero flags.
// Assumes the decode stage supplies both source register values with the
// instruction word, and the register file takes the write-back.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - subf writes second source plus inverted first source plus one.
// - subf is opcode 31, extended 40; carry flag untouched.
// - subfc is opcode 31, extended 8; same difference, updates carry.
// - carrying forms set carry on unsigned overflow past 32 bits, else clear.
// - subfe, extended 136, adds inverted first, second and carry.
// - subfme adds inverted first source, minus one and carry.
// - subfme is opcode 31, extended 232; second source field ignored.
// - nonzero reserved bits in subfme give no program exception.
// - subfic sign-extends 16-bit immediate, adds it plus one to inverted first.
// - subfic is primary 8; touches only destination and carry.
// - record bit set updates sign, zero and summary bits of condition field zero.
// - overflow-enable set updates overflow and summary; clear leaves both.
// - these subtracts never raise any exception.
module sfalu_top
    import sfalu_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Issue from decode
    input  wire sfalu_issue_t issue,
    // Write-back to register file
    output sfalu_wb_t         wb,
    output logic              program_exception,
    // Architected flags
    output logic [31:0]       fixed_point_exception_reg,
    output logic [3:0]        condition_field_zero,
    // Register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [31:0]       reg_rdata
);

    // ********************************************************
    // Decode
    // ********************************************************
    sfalu_kind_t dec_kind;
    logic        dec_oe;
    logic        dec_record;
    logic [5:0]  dec_prim;
    logic [8:0]  dec_xo;
    logic [4:0]  dec_dest;

    always_comb
    begin
        dec_prim = issue.instr[SFALU_POS_PRIM_LSB +: 6];
        dec_dest = issue.instr[SFALU_POS_DEST_LSB +: 5];
        dec_xo   = issue.instr[SFALU_POS_XO_LSB +: 9];
        dec_oe   = issue.instr[SFALU_POS_OE];
        dec_record = issue.instr[SFALU_POS_RECORD];
        dec_kind = SFALU_K_NONE;
        if (issue.valid && dec_prim == SFALU_OP_SUBFIC)
        begin
            dec_kind = SFALU_K_SUBFIC;
        end
        else if (issue.valid && dec_prim == SFALU_OP_XFORM)
        begin
            case (dec_xo)
                SFALU_XO_SUBF:   dec_kind = SFALU_K_SUBF;
                SFALU_XO_SUBFC:  dec_kind = SFALU_K_SUBFC;
                SFALU_XO_SUBFE:  dec_kind = SFALU_K_SUBFE;
                SFALU_XO_SUBFME: dec_kind = SFALU_K_SUBFME;
                default:         dec_kind = SFALU_K_NONE;
            endcase
        end
    end

    // ********************************************************
    // Operand selection and adder
    // ********************************************************
    logic [31:0] op_b;
    logic        op_cin;
    logic [31:0] add_sum;
    logic        add_cout;
    logic        add_ovf;
    logic        cur_carry;

    always_comb
    begin
        cur_carry = fixed_point_exception_reg[SFALU_FX_CARRY];
        op_b   = issue.src_b;
        op_cin = 1'b1;
        case (dec_kind)
            SFALU_K_SUBF, SFALU_K_SUBFC: op_b = issue.src_b;
            SFALU_K_SUBFE:
            begin
                op_b   = issue.src_b;
                op_cin = cur_carry;
            end
            SFALU_K_SUBFME:
            begin
                op_b   = 32'hffff_ffff;
                op_cin = cur_carry;
            end
            SFALU_K_SUBFIC: op_b = {{16{issue.instr[15]}}, issue.instr[15:0]};
            default:        op_b = issue.src_b;
        endcase
    end

    sfalu_adder #(
        .W   (32)
    ) u_adder (
        .a   (~issue.src_a),
        .b   (op_b),
        .cin (op_cin),
        .sum (add_sum),
        .cout(add_cout),
        .ovf (add_ovf)
    );

    // ********************************************************
    // Write-back
    // ********************************************************
    sfalu_wb_t next_wb;
    logic      next_program_exception;

    always_comb
    begin
        next_wb.valid = (dec_kind != SFALU_K_NONE);
        next_wb.dest  = dec_dest;
        next_wb.data  = add_sum;
        next_program_exception = 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb                <= '0;
            program_exception <= 1'b0;
        end
        else
        begin
            wb                <= next_wb;
            program_exception <= next_program_exception;
        end
    end

    // ********************************************************
    // Flags
    // ********************************************************
    // Software writes apply first; an instruction's flag update in the
    // same cycle overrides the bits it touches, so no event is lost.
    logic [31:0] next_fx;
    logic [3:0]  next_cf;
    logic        is_reg_form;
    logic        new_so;

    always_comb
    begin
        next_fx = fixed_point_exception_reg;
        next_cf = condition_field_zero;
        if (reg_wr && reg_addr == SFALU_OFF_FX)
        begin
            next_fx = reg_wdata & SFALU_FX_MASK;
        end
        if (reg_wr && reg_addr == SFALU_OFF_CF)
        begin
            next_cf = reg_wdata[3:0];
        end
        is_reg_form = (dec_kind != SFALU_K_NONE)
                      && (dec_kind != SFALU_K_SUBFIC);
        if (dec_kind != SFALU_K_NONE && dec_kind != SFALU_K_SUBF)
        begin
            next_fx[SFALU_FX_CARRY] = add_cout;
        end
        if (is_reg_form && dec_oe)
        begin
            next_fx[SFALU_FX_OVF] = add_ovf;
            next_fx[SFALU_FX_SUM] = next_fx[SFALU_FX_SUM] | add_ovf;
        end
        new_so = next_fx[SFALU_FX_SUM];
        if (is_reg_form && dec_record)
        begin
            next_cf[SFALU_CF_LESS]    = add_sum[31];
            next_cf[SFALU_CF_GREATER] = !add_sum[31]
                                        && (add_sum != 32'h0000_0000);
            next_cf[SFALU_CF_EQUAL]   = (add_sum == 32'h0000_0000);
            next_cf[SFALU_CF_SUM]     = new_so;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fixed_point_exception_reg <= SFALU_FX_RST;
            condition_field_zero      <= SFALU_CF_RST;
        end
        else
        begin
            fixed_point_exception_reg <= next_fx;
            condition_field_zero      <= next_cf;
        end
    end

    // ********************************************************
    // Register read port
    // ********************************************************
    logic [31:0] next_reg_rdata;

    always_comb
    begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd && reg_addr == SFALU_OFF_FX)
        begin
            next_reg_rdata = fixed_point_exception_reg;
        end
        else if (reg_rd && reg_addr == SFALU_OFF_CF)
        begin
            next_reg_rdata = {28'h000_0000, condition_field_zero};
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [31:0] p_a;
    logic [31:0] p_b;
    logic [31:0] p_imm;
    logic        p_carry;
    logic        p_oe;
    logic        p_record;

    always_comb
    begin
        p_a   = issue.src_a;
        p_b   = issue.src_b;
        p_imm = {{16{issue.instr[15]}}, issue.instr[15:0]};
        p_carry  = fixed_point_exception_reg[SFALU_FX_CARRY];
        p_oe     = dec_oe;
        p_record = dec_record;
    end

    sequence s_subf;
        dec_kind == SFALU_K_SUBF;
    endsequence

    sequence s_subfc;
        dec_kind == SFALU_K_SUBFC;
    endsequence

    sequence s_subfe;
        dec_kind == SFALU_K_SUBFE;
    endsequence

    sequence s_subfme;
        dec_kind == SFALU_K_SUBFME;
    endsequence

    sequence s_subfic;
        dec_kind == SFALU_K_SUBFIC;
    endsequence

    a_subf_result: assert property (
        s_subf |=> wb.valid && wb.data == $past(p_b) - $past(p_a))
        else $error("subf result wrong");

    a_subf_keeps_carry: assert property (
        (s_subf and !reg_wr)
        |=> $stable(fixed_point_exception_reg[SFALU_FX_CARRY]))
        else $error("subf changed carry");

    a_subfc_carry_out: assert property (
        s_subfc |=> fixed_point_exception_reg[SFALU_FX_CARRY]
                    == ($past(p_b) >= $past(p_a)))
        else $error("subfc carry wrong");

    a_subfic_carry_out: assert property (
        s_subfic |=> fixed_point_exception_reg[SFALU_FX_CARRY]
                     == ($past(p_imm) >= $past(p_a)))
        else $error("subfic carry wrong");

    a_subfe_result: assert property (
        s_subfe |=> wb.data == $past(p_b) - $past(p_a) - 32'h1
                               + {31'h0, $past(p_carry)})
        else $error("subfe result wrong");

    a_subfme_result: assert property (
        s_subfme |=> wb.data == 32'h0 - $past(p_a) - 32'h2
                                + {31'h0, $past(p_carry)})
        else $error("subfme result wrong");

    a_no_exception: assert property (
        !program_exception)
        else $error("exception raised");

    a_subfic_result: assert property (
        s_subfic |=> wb.data == $past(p_imm) - $past(p_a))
        else $error("subfic result wrong");

    a_subfic_no_flags: assert property (
        (s_subfic and !reg_wr) |=> $stable(condition_field_zero)
            && $stable(fixed_point_exception_reg[SFALU_FX_SUM:SFALU_FX_OVF]))
        else $error("subfic touched condition or overflow");

    a_record_fields: assert property (
        dec_kind != SFALU_K_NONE && dec_kind != SFALU_K_SUBFIC && p_record
        |=> condition_field_zero[SFALU_CF_EQUAL] == (wb.data == 32'h0)
            && condition_field_zero[SFALU_CF_LESS] == wb.data[31]
            && condition_field_zero[SFALU_CF_GREATER]
               == (!wb.data[31] && wb.data != 32'h0)
            && condition_field_zero[SFALU_CF_SUM]
               == fixed_point_exception_reg[SFALU_FX_SUM])
        else $error("record field wrong");

    a_oe_clear_keeps: assert property (
        dec_kind != SFALU_K_NONE && !p_oe && !reg_wr
        |=> $stable(fixed_point_exception_reg[SFALU_FX_SUM:SFALU_FX_OVF]))
        else $error("overflow changed with enable clear");

    a_so_sticky: assert property (
        fixed_point_exception_reg[SFALU_FX_SUM] && !reg_wr
        |=> fixed_point_exception_reg[SFALU_FX_SUM])
        else $error("summary overflow lost");

endmodule // sfalu_top

`default_nettype wire

// >>> pkg/sfalu_pkg.sv
// Package of the subtract-from datapath: opcodes, instruction field
// positions, flag positions, register offsets, reset values and carriers.
// Assumes instruction words arrive with big-endian bit 0 in bit 31.
`default_nettype none

package sfalu_pkg;

    // ********************************************************
    // Opcodes
    // ********************************************************
    localparam logic [5:0] SFALU_OP_XFORM  = 6'h1f;
    localparam logic [5:0] SFALU_OP_SUBFIC = 6'h08;
    localparam logic [8:0] SFALU_XO_SUBF   = 9'h028;
    localparam logic [8:0] SFALU_XO_SUBFC  = 9'h008;
    localparam logic [8:0] SFALU_XO_SUBFE  = 9'h088;
    localparam logic [8:0] SFALU_XO_SUBFME = 9'h0e8;

    // ********************************************************
    // Instruction field positions (little-endian index)
    // ********************************************************
    localparam int SFALU_POS_PRIM_LSB = 26;
    localparam int SFALU_POS_DEST_LSB = 21;
    localparam int SFALU_POS_OE       = 10;
    localparam int SFALU_POS_XO_LSB   = 1;
    localparam int SFALU_POS_RECORD   = 0;

    // ********************************************************
    // Flag positions and reset values
    // ********************************************************
    localparam int SFALU_FX_SUM     = 31;
    localparam int SFALU_FX_OVF     = 30;
    localparam int SFALU_FX_CARRY   = 29;
    localparam int SFALU_CF_LESS    = 3;
    localparam int SFALU_CF_GREATER = 2;
    localparam int SFALU_CF_EQUAL   = 1;
    localparam int SFALU_CF_SUM     = 0;
    localparam logic [31:0] SFALU_FX_RST  = 32'h0000_0000;
    localparam logic [31:0] SFALU_FX_MASK = 32'he000_0000;
    localparam logic [3:0]  SFALU_CF_RST  = 4'h0;

    // ********************************************************
    // Register port
    // ********************************************************
    localparam logic [7:0] SFALU_OFF_FX = 8'h00;
    localparam logic [7:0] SFALU_OFF_CF = 8'h04;

    typedef enum logic [2:0] {
        SFALU_K_NONE,
        SFALU_K_SUBF,
        SFALU_K_SUBFC,
        SFALU_K_SUBFE,
        SFALU_K_SUBFME,
        SFALU_K_SUBFIC
    } sfalu_kind_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] src_a;
        logic [31:0] src_b;
    } sfalu_issue_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [31:0] data;
    } sfalu_wb_t;

endpackage

`default_nettype wire

// >>> design/sfalu_adder.sv
// Three-input adder with carry out and signed overflow.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ns
`default_nettype none

module sfalu_adder #(
    parameter int W = 32
) (
    // Operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         cin,
    // Results
    output logic      [W-1:0] sum,
    output logic              cout,
    output logic              ovf
);

    always_comb
    begin
        {cout, sum} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
    end

endmodule // sfalu_adder

`default_nettype wire

// >>> dv/sfalu_dec_model.sv
// Decode stage and register file model facing the subtract-from unit.
// Assumes the bench offers one instruction per go pulse with operands.
`timescale 1ns/1ns
`default_nettype none

module sfalu_dec_model
    import sfalu_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Request from bench
    input  wire logic         go,
    input  wire logic [31:0]  instr_in,
    input  wire logic [31:0]  a_in,
    input  wire logic [31:0]  b_in,
    // Unit side
    output sfalu_issue_t      issue,
    input  wire sfalu_wb_t    wb
);
    logic [31:0] gpr [32];

    // Idle words are inverted so a stale operand never looks usable
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            issue <= '0;
        else if (go)
            issue <= {1'b1, instr_in, a_in, b_in};
        else
            issue <= {1'b0, ~issue.instr, ~issue.src_a, ~issue.src_b};
    end

    always_ff @(posedge clk)
    begin
        if (wb.valid)
            gpr[wb.dest] <= wb.data;
    end
endmodule // sfalu_dec_model

`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench of the subtract-from unit: random and corner
// instructions through the decode model, flags and register port.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb;
    import sfalu_pkg::*;

    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         go = 1'b0;
    logic [31:0]  ins = '0;
    logic [31:0]  opa = '0;
    logic [31:0]  opb = '0;
    sfalu_issue_t issue;
    sfalu_wb_t    wb;
    logic         prog_exc;
    logic [31:0]  fx_reg;
    logic [3:0]   cfz;
    logic [7:0]   reg_addr = '0;
    logic [31:0]  reg_wdata = '0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic [31:0]  seed = 32'h0000_001c;
    logic [2:0]   ex_f = '0;
    logic [3:0]   ex_cr = '0;
    logic [31:0]  r;
    int           err_total = 0;
    int           compares = 0;

    always #25 clk = ~clk;

    sfalu_dec_model u_dec (.clk(clk), .sys_rst(sys_rst), .go(go),
        .instr_in(ins), .a_in(opa), .b_in(opb), .issue(issue), .wb(wb));

    sfalu_top DUT (.clk(clk), .sys_rst(sys_rst), .issue(issue), .wb(wb),
        .program_exception(prog_exc), .fixed_point_exception_reg(fx_reg),
        .condition_field_zero(cfz), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Returns {decoded, signed overflow, carry, result}
    function automatic logic [34:0] ref_op(input logic [31:0] iw,
        input logic [31:0] a, input logic [31:0] b, input logic carry);
        logic [31:0] s;
        logic        ci;
        logic        dec;
        logic [32:0] t;
        dec = 1'b1;
        ci = 1'b1;
        s = b;
        if (iw[31:26] == SFALU_OP_SUBFIC)
            s = {{16{iw[15]}}, iw[15:0]};
        else if (iw[31:26] != SFALU_OP_XFORM)
            dec = 1'b0;
        else if (iw[9:1] == SFALU_XO_SUBFE)
            ci = carry;
        else if (iw[9:1] == SFALU_XO_SUBFME)
        begin
            ci = carry;
            s = 32'hffff_ffff;
        end
        else if (iw[9:1] != SFALU_XO_SUBF && iw[9:1] != SFALU_XO_SUBFC)
            dec = 1'b0;
        t = {1'b0, ~a} + {1'b0, s} + {32'h0, ci};
        return {dec, (~a[31] == s[31]) && (t[31] != s[31]), t};
    endfunction

    function automatic logic [31:0] mk(input logic [31:0] v);
        logic [8:0] x;
        case (v[29:28])
            2'h0: x = SFALU_XO_SUBF;
            2'h1: x = SFALU_XO_SUBFC;
            2'h2: x = SFALU_XO_SUBFE;
            default: x = SFALU_XO_SUBFME;
        endcase
        if (v[31:30] == 2'h3)
            return {SFALU_OP_SUBFIC, v[25:0]};
        return {SFALU_OP_XFORM, v[25:11], v[10], x, v[0]};
    endfunction

    function automatic logic [31:0] pick(input logic [31:0] v);
        case (v[2:0])
            3'h0: return 32'h0;
            3'h1: return 32'hffff_ffff;
            3'h2: return 32'h8000_0000;
            3'h3: return 32'h7fff_ffff;
            default: return v;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        // Read data stand one cycle only, then fall back to zero
        @(posedge clk);
        #1;
        chk(reg_rdata, 32'h0);
    endtask

    task automatic run(input logic [31:0] iw, input logic [31:0] a,
        input logic [31:0] b);
        logic [34:0] e;
        logic        imm;
        e = ref_op(iw, a, b, ex_f[0]);
        imm = (iw[31:26] == SFALU_OP_SUBFIC);
        @(posedge clk);
        go <= 1'b1;
        ins <= iw;
        opa <= a;
        opb <= b;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        if (e[34] && (imm || iw[9:1] != SFALU_XO_SUBF))
            ex_f[0] = e[32];
        if (e[34] && !imm && iw[10])
            ex_f[2:1] = {ex_f[2] | e[33], e[33]};
        if (e[34] && !imm && iw[0])
            ex_cr = {e[31], !e[31] && e[31:0] != 0, e[31:0] == 0, ex_f[2]};
        chk({31'h0, wb.valid}, {31'h0, e[34]});
        if (e[34])
            chk(wb.data, e[31:0]);
        if (e[34])
            chk({27'h0, wb.dest}, {27'h0, iw[25:21]});
        chk(fx_reg, {ex_f, 29'h0});
        chk({28'h0, cfz}, {28'h0, ex_cr});
        chk({31'h0, prog_exc}, 32'h0);
        // The register file model takes the result one edge later
        if (e[34])
        begin
            @(posedge clk);
            #1;
            chk(u_dec.gpr[iw[25:21]], e[31:0]);
        end
    endtask

    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Generous bound: the sequence needs under 2000 cycles
    initial
    begin
        #(20000 * 50);
        err_total++;
        final_report();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        ex_f = 3'h7;
        rd(8'h00, 32'he000_0000);
        wr(SFALU_OFF_CF, 32'hffff_fff5);
        ex_cr = 4'h5;
        rd(SFALU_OFF_CF, 32'h0000_0005);
        rd(8'h0c, 32'h0);
        run({SFALU_OP_XFORM, 10'h0a5, 5'h1f, 1'b1, SFALU_XO_SUBFME, 1'b1},
            32'h0, 32'h0);
        run({SFALU_OP_XFORM, 15'h1462, 1'b0, SFALU_XO_SUBFE, 1'b0},
            32'h1, 32'h1);
        // Undecoded extended code leaves everything alone
        run({SFALU_OP_XFORM, 15'h0, 1'b1, 9'h10a, 1'b1}, 32'h5, 32'h9);
        run({SFALU_OP_SUBFIC, 10'h021, 16'h8000}, 32'h7fff_ffff, 32'h0);
        wr(8'h00, 32'h0);
        ex_f = 3'h0;
        for (int i = 0; i < 300; i++)
        begin
            seed = xs(seed);
            r = seed;
            seed = xs(seed);
            run(mk(r), pick(seed), pick(xs(seed)));
        end
        final_report();
    end
endmodule // tb

`default_nettype wire
